// ### design/phy_pins_pkg.sv
// constants for the status, strap and led pin logic of the transceiver
// assumes a 125 mhz system clock and a management host on mdc/mdio

package phy_pins_pkg;

  // ----------------------------------------------------------------
  // widths and frame layout of the management serial port
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 5;
  localparam int REG_W     = 16;
  localparam int HDR_BITS  = 12;
  localparam int TA_BITS   = 2;
  localparam int DATA_BITS = 16;
  localparam int HDR_OP_HI = 11;
  localparam int HDR_OP_LO = 10;
  localparam int HDR_PA_HI = 9;
  localparam int HDR_PA_LO = 5;
  localparam int HDR_RA_HI = 4;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_WRITE   = 2'h1;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_INT_STAT  = 5'h12;
  localparam logic [4:0]  REG_LED_CFG   = 5'h13;
  localparam logic [4:0]  REG_ADDR_STAT = 5'h14;
  localparam logic [15:0] LED_CFG_RST   = 16'h0000;
  localparam int LED_ONE_POS   = 0;
  localparam int LED_TWO_POS   = 2;
  localparam int LED_THREE_POS = 4;
  localparam int WATCH_W_DFLT  = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ   = 125;
  localparam int LED_HOLD_MS   = 100;
  localparam int LED_HOLD_CYC  = LED_HOLD_MS * 1000 * SYS_CLK_MHZ;

  typedef enum logic [1:0] {
    LED_DEFAULT   = 2'h0,
    LED_EVENT     = 2'h1,
    LED_FORCE_OFF = 2'h2,
    LED_FORCE_ON  = 2'h3
  } led_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HEAD = 4'h2,
    ST_TURN = 4'h4,
    ST_DATA = 4'h8
  } mgmt_state_e;

endpackage

// ### design/phy_status_pins.sv
// receive error, collision, management interrupt, led and address strap pins
// assumes pin inputs are asynchronous to sys_clk; status inputs are on sys_clk

`timescale 1ns/1ns

// Function
// (RULE1) receive error goes high on a coding error and updates at receive clock falls.
// (RULE2) with the decoder bypassed the receive error pin carries the fifth symbol bit.
// (RULE3) collision goes high while transmit and receive activity overlap.
// (RULE4) management data is shifted in and out on rising edges of the host's mdc.
// (RULE5) the interrupt pin is pulled low when any watched status bit changes.
// (RULE6) the interrupt is released only after every changed bit has been read.
// (RULE7) the interrupt pin floats in reset and its level becomes address bit 4.
// (RULE8) led three by default is low while a 100 mbps link is up, else high.
// (RULE9) each led can be reassigned to another event or forced by the user; here only leds one to three take a mode, led zero is never driven.
// (RULE10) led three floats in reset and its level becomes address bit 3.
// (RULE11) led two by default goes low on a packet and holds low for 100 ms.
// (RULE12) led two floats in reset and its level becomes address bit 2.
// (RULE13) led one by default is low in full duplex and high in half duplex.
// (RULE14) led one floats in reset and its level becomes address bit 1.
// (RULE15) led zero floats in reset and its level becomes address bit 0.
// (RULE16) the latched address holds until reset and is matched against each frame.
module phy_status_pins
  import phy_pins_pkg::*;
#(
  parameter int WATCH_W     = WATCH_W_DFLT,
  parameter int HOLD_CYCLES = LED_HOLD_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               rx_clk_pin,
  input  wire logic               rx_coding_err,
  input  wire logic               rx_sym_bit4,
  input  wire logic               decoder_bypass,
  input  wire logic               tx_active,
  input  wire logic               rx_active,
  input  wire logic               link_100,
  input  wire logic               full_duplex,
  input  wire logic               tx_packet,
  input  wire logic               rx_packet,
  input  wire logic [WATCH_W-1:0] watch_bits,
  input  wire logic               mdc,
  input  wire logic               mdio_i,
  output logic                    mdio_o,
  output logic                    mdio_oe,
  output logic                    rx_err_out,
  output logic                    col_out,
  input  wire logic               mgmt_interrupt_n_i,
  output logic                    mgmt_interrupt_n_o,
  output logic                    mgmt_interrupt_n_oe,
  input  wire logic               led_out_three_i,
  output logic                    led_out_three_o,
  output logic                    led_out_three_oe,
  input  wire logic               led_out_two_i,
  output logic                    led_out_two_o,
  output logic                    led_out_two_oe,
  input  wire logic               led_out_one_i,
  output logic                    led_out_one_o,
  output logic                    led_out_one_oe,
  input  wire logic               led_out_zero_i,
  output logic [ADDR_W-1:0]       phy_addr,
  output logic                    phy_addr_valid
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES - 1);
  localparam int NPIN = 8;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // data flops only: no reset so the strap level seen in reset survives
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;

  assign pin_raw = {mgmt_interrupt_n_i, led_out_three_i, led_out_two_i, led_out_one_i,
                    led_out_zero_i, mdio_i, mdc, rx_clk_pin};

  always_ff @(posedge sys_clk) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  logic rxclk_fall;
  logic mdc_rise;
  logic mdio_bit;
  assign rxclk_fall = pin_s3_q[0] & ~pin_s2_q[0];
  assign mdc_rise   = pin_s2_q[1] & ~pin_s3_q[1];
  assign mdio_bit   = pin_s2_q[2];

  // ----------------------------------------------------------------
  // receive error and collision
  // ----------------------------------------------------------------
  logic rx_err_q;
  logic col_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_err_q <= 1'b0;
    end else if (rxclk_fall) begin
      rx_err_q <= decoder_bypass ? rx_sym_bit4 : rx_coding_err; // (RULE1) (RULE2)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      col_q <= 1'b0;
    end else begin
      col_q <= tx_active & rx_active; // (RULE3)
    end
  end

  assign rx_err_out = rx_err_q;
  assign col_out    = col_q;

  // ----------------------------------------------------------------
  // address strap
  // ----------------------------------------------------------------
  // pins stay released until the level is caught one edge after release
  logic              strap_done_q;
  logic [ADDR_W-1:0] phy_addr_q;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
      phy_addr_q   <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      phy_addr_q   <= pin_s2_q[7:3]; // (RULE7) (RULE10) (RULE12) (RULE14) (RULE15) (RULE16)
    end
  end

  assign phy_addr       = phy_addr_q;
  assign phy_addr_valid = strap_done_q;

  // ----------------------------------------------------------------
  // management frame engine
  // ----------------------------------------------------------------
  mgmt_state_e          state_q;
  logic [4:0]           cnt_q;
  logic                 prev_bit_q;
  logic [HDR_BITS-1:0]  hdr_q;
  logic [REG_W-1:0]     data_q;
  logic                 rd_q;
  logic                 hit_q;
  logic                 int_clr_q;
  logic [WATCH_W-1:0]   int_stat_q;
  logic [WATCH_W-1:0]   int_snap_q;
  logic [REG_W-1:0]     led_cfg_q;
  logic                 mdio_o_q;
  logic                 mdio_oe_q;
  logic [HDR_BITS-1:0]  hdr_n;

  assign hdr_n = {hdr_q[HDR_BITS-2:0], mdio_bit};

  function automatic logic [REG_W-1:0] reg_read(input logic [4:0] ra);
    case (ra)
      REG_INT_STAT:  reg_read = REG_W'(int_stat_q);
      REG_LED_CFG:   reg_read = led_cfg_q;
      REG_ADDR_STAT: reg_read = REG_W'(phy_addr_q);
      default:       reg_read = '0;
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= '0;
      prev_bit_q <= 1'b1;
      hdr_q      <= '0;
      data_q     <= '0;
      rd_q       <= 1'b0;
      hit_q      <= 1'b0;
      int_clr_q  <= 1'b0;
      int_snap_q <= '0;
      led_cfg_q  <= LED_CFG_RST;
      mdio_o_q   <= 1'b0;
      mdio_oe_q  <= 1'b0;
    end else begin
      int_clr_q <= 1'b0;
      if (mdc_rise && strap_done_q) begin // (RULE4)
        case (state_q)
          ST_IDLE: begin
            prev_bit_q <= mdio_bit;
            if ({prev_bit_q, mdio_bit} == START_CODE) begin
              state_q <= ST_HEAD;
              cnt_q   <= '0;
            end
          end
          ST_HEAD: begin
            hdr_q <= hdr_n;
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == 5'(HDR_BITS - 1)) begin
              state_q <= ST_TURN;
              cnt_q   <= '0;
              hit_q   <= hdr_n[HDR_PA_HI:HDR_PA_LO] == phy_addr_q; // (RULE16)
              rd_q    <= hdr_n[HDR_OP_HI:HDR_OP_LO] == OP_READ;
              data_q  <= reg_read(hdr_n[HDR_RA_HI:0]);
              if (hdr_n[HDR_RA_HI:0] == REG_INT_STAT) begin
                int_snap_q <= int_stat_q; // (RULE6)
              end
            end
          end
          ST_TURN: begin
            cnt_q <= cnt_q + 5'h1;
            if (rd_q && hit_q) begin
              mdio_oe_q <= 1'b1;
              mdio_o_q  <= (cnt_q == 5'(TA_BITS - 1)) ? data_q[REG_W-1] : 1'b0;
              if (cnt_q == 5'(TA_BITS - 1)) begin
                data_q <= {data_q[REG_W-2:0], 1'b0};
              end
            end
            if (cnt_q == 5'(TA_BITS - 1)) begin
              state_q <= ST_DATA;
              cnt_q   <= '0;
            end
          end
          ST_DATA: begin
            cnt_q <= cnt_q + 5'h1;
            if (rd_q) begin
              mdio_o_q <= data_q[REG_W-1];
              data_q   <= {data_q[REG_W-2:0], 1'b0};
            end else begin
              data_q <= {data_q[REG_W-2:0], mdio_bit};
            end
            if (cnt_q == 5'(DATA_BITS - 1)) begin
              state_q    <= ST_IDLE;
              prev_bit_q <= 1'b1;
              mdio_oe_q  <= 1'b0;
              if (hit_q && rd_q && hdr_q[HDR_RA_HI:0] == REG_INT_STAT) begin
                int_clr_q <= 1'b1; // (RULE6)
              end
              if (hit_q && !rd_q && hdr_q[HDR_OP_HI:HDR_OP_LO] == OP_WRITE &&
                  hdr_q[HDR_RA_HI:0] == REG_LED_CFG) begin
                led_cfg_q <= {data_q[REG_W-2:0], mdio_bit}; // (RULE9)
              end
            end
          end
          default: begin
            state_q   <= ST_IDLE;
            mdio_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign mdio_o  = mdio_o_q;
  assign mdio_oe = mdio_oe_q;

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  logic [WATCH_W-1:0] watch_prev_q;
  logic               int_oe_q;

  always_ff @(posedge sys_clk) begin
    watch_prev_q <= watch_bits;
  end

  // new changes win over the clear of an older snapshot
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      int_stat_q <= '0;
    end else if (strap_done_q) begin
      int_stat_q <= (int_stat_q & ~(int_clr_q ? int_snap_q : '0))
                  | (watch_bits ^ watch_prev_q); // (RULE5) (RULE6)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      int_oe_q <= 1'b0; // (RULE7)
    end else begin
      int_oe_q <= strap_done_q & (|int_stat_q); // (RULE5)
    end
  end

  assign mgmt_interrupt_n_o  = 1'b0;
  assign mgmt_interrupt_n_oe = int_oe_q;

  // ----------------------------------------------------------------
  // leds
  // ----------------------------------------------------------------
  // index 0 activity, 1 collision; one counter each, 100 ms hold
  logic [1:0]    evt_trig;
  logic [1:0]    evt_on;
  logic [HW-1:0] hold_q [2];

  assign evt_trig = {col_q, tx_packet | rx_packet};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_hold
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          hold_q[g] <= '0;
        end else if (evt_trig[g]) begin
          hold_q[g] <= HOLD_LOAD; // (RULE11)
        end else if (hold_q[g] != '0) begin
          hold_q[g] <= hold_q[g] - HW'(1);
        end
      end
      assign evt_on[g] = evt_trig[g] | (hold_q[g] != '0);
    end
  endgenerate

  function automatic logic led_lit(input logic [1:0] mode, input logic dflt, input logic evt);
    case (mode)
      LED_DEFAULT:   led_lit = dflt;
      LED_EVENT:     led_lit = evt;
      LED_FORCE_OFF: led_lit = 1'b0;
      default:       led_lit = 1'b1;
    endcase
  endfunction

  // led one pulls both ways; two and three are open drain
  localparam logic [2:0] PUSH_PULL = 3'h1;
  logic [2:0] led_dflt;
  logic [2:0] led_o_q;
  logic [2:0] led_oe_q;
  logic [5:0] led_modes;

  assign led_dflt  = {link_100, evt_on[0], full_duplex}; // (RULE8) (RULE11) (RULE13)
  assign led_modes = {led_cfg_q[LED_THREE_POS+:2], led_cfg_q[LED_TWO_POS+:2],
                      led_cfg_q[LED_ONE_POS+:2]};

  generate
    for (g = 0; g < 3; g++) begin : g_led
      logic lit;
      assign lit = led_lit(led_modes[2*g+:2], led_dflt[g], evt_on[1]); // (RULE9)
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          led_o_q[g]  <= 1'b1;
          led_oe_q[g] <= 1'b0; // (RULE10) (RULE12) (RULE14)
        end else begin
          led_o_q[g]  <= ~lit; // (RULE8) (RULE13)
          led_oe_q[g] <= strap_done_q & (PUSH_PULL[g] | lit);
        end
      end
    end
  endgenerate

  assign led_out_one_o    = led_o_q[0];
  assign led_out_one_oe   = led_oe_q[0];
  assign led_out_two_o    = led_o_q[1];
  assign led_out_two_oe   = led_oe_q[1];
  assign led_out_three_o  = led_o_q[2];
  assign led_out_three_oe = led_oe_q[2];

endmodule

// ### sim/mgmt_host.sv
// station management host model: drives mdc and its side of mdio
// mdio has a pull-up; the device drives it only while mdio_oe is high
`timescale 1ns/1ns
module mgmt_host
  import phy_pins_pkg::*;
(
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_line
);
  logic drv;
  logic en;
  // released line floats up, never keeps the last bit
  assign mdio_line = mdio_oe ? mdio_o : (en ? drv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    en  = 1'b0;
  end
  // mdc runs only inside a frame; bits change while mdc is low
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] v;
    v  = {START_CODE, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      drv = v[31-i];
      en  = !(op == OP_READ && i >= 14);
      #40 mdc = 1'b1;
      if (i >= 16) rd = {rd[14:0], mdio_line};
      #40 mdc = 1'b0;
    end
    en = 1'b0;
  endtask
endmodule

// ### sim/phy_pins_monitor.sv
// checker for the status, strap and led pin block
// bound to phy_status_pins at the foot; sees its ports only
`timescale 1ns/1ns
module phy_pins_monitor
  import phy_pins_pkg::*;
#(
  parameter int WATCH_W = WATCH_W_DFLT
) (
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire logic               rx_clk_pin,
  input wire logic               rx_coding_err,
  input wire logic               rx_sym_bit4,
  input wire logic               decoder_bypass,
  input wire logic               tx_active,
  input wire logic               rx_active,
  input wire logic               link_100,
  input wire logic               tx_packet,
  input wire logic               rx_packet,
  input wire logic               mdc,
  input wire logic               mdio_o,
  input wire logic               mdio_oe,
  input wire logic               rx_err_out,
  input wire logic               col_out,
  input wire logic               mgmt_interrupt_n_i,
  input wire logic               mgmt_interrupt_n_oe,
  input wire logic               led_out_three_i,
  input wire logic               led_out_three_oe,
  input wire logic               led_out_two_i,
  input wire logic               led_out_two_oe,
  input wire logic               led_out_one_i,
  input wire logic               led_out_zero_i,
  input wire logic               phy_addr_valid,
  input wire logic [WATCH_W-1:0] watch_bits,
  input wire logic [ADDR_W-1:0]  phy_addr
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  wire logic [ADDR_W-1:0] strap_w;
  // straps are stable through reset, so a sample three cycles back is safe
  assign strap_w = {mgmt_interrupt_n_i, led_out_three_i, led_out_two_i, led_out_one_i,
                    led_out_zero_i};
  col_set_a: assert property (tx_active && rx_active |=> col_out)
    else $error("collision not raised");
  col_clear_a: assert property (!(tx_active && rx_active) |=> !col_out)
    else $error("collision without overlap");
  strap_latch_a: assert property ($rose(phy_addr_valid) |-> phy_addr == $past(strap_w, 3))
    else $error("address not latched from pins");
  addr_hold_a: assert property (phy_addr_valid |=> $stable(phy_addr))
    else $error("latched address moved");
  int_set_a: assert property (phy_addr_valid && $past(phy_addr_valid)
    && watch_bits != $past(watch_bits) |-> ##[1:3] mgmt_interrupt_n_oe)
    else $error("interrupt not pulled low");
  led_link_a: assert property (phy_addr_valid && $past(phy_addr_valid)
    |-> led_out_three_oe == $past(link_100))
    else $error("link led wrong");
  led_hold_a: assert property (phy_addr_valid && $past(phy_addr_valid)
    && (tx_packet || rx_packet) |-> ##[1:2] led_out_two_oe [*8])
    else $error("activity led not held");
  rxerr_edge_a: assert property ($changed(rx_err_out) |-> !$past(rx_clk_pin, 3))
    else $error("receive error moved off a clock fall");
  rxerr_val_a: assert property ($changed(rx_err_out) |-> rx_err_out ==
    ($past(decoder_bypass) ? $past(rx_sym_bit4) : $past(rx_coding_err)))
    else $error("receive error source wrong");
  mdio_ta_a: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround not driven low");
  mdio_edge_a: assert property ($changed(mdio_o) |-> $past(mdc, 2))
    else $error("mdio changed away from an mdc rise");
endmodule

bind phy_status_pins phy_pins_monitor #(.WATCH_W(WATCH_W)) u_phy_pins_monitor (
  .sys_clk, .resetn, .rx_clk_pin, .rx_coding_err, .rx_sym_bit4, .decoder_bypass,
  .tx_active, .rx_active, .link_100, .tx_packet, .rx_packet, .mdc, .mdio_o, .mdio_oe,
  .rx_err_out, .col_out, .mgmt_interrupt_n_i, .mgmt_interrupt_n_oe, .led_out_three_i,
  .led_out_three_oe, .led_out_two_i, .led_out_two_oe, .led_out_one_i, .led_out_zero_i,
  .phy_addr_valid, .watch_bits, .phy_addr
);

// ### sim/phy_status_pins_bench.sv
// self-checking bench for the status, strap and led pin block
// strap pins resolve here from the pin drivers and a fixed strap pattern
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module phy_status_pins_bench
  import phy_pins_pkg::*;
();
  localparam logic [4:0] STRAP = 5'h1e;
  logic sys_clk, resetn, rx_clk_pin, rx_coding_err, rx_sym_bit4, decoder_bypass;
  logic tx_active, rx_active, link_100, full_duplex, tx_packet, rx_packet;
  logic mdc, mdio_line, mdio_o, mdio_oe, rx_err_out, col_out, phy_addr_valid;
  logic int_i, int_o, int_oe, l3_i, l3_o, l3_oe, l2_i, l2_o, l2_oe, l1_i, l1_o, l1_oe;
  logic [3:0]  watch_bits;
  logic [4:0]  phy_addr;
  logic [15:0] rd;
  int          n_errors;
  int          cmp_count;
  int          cyc;
  assign int_i = int_oe ? int_o : STRAP[4];
  assign l3_i  = l3_oe ? l3_o : STRAP[3];
  assign l2_i  = l2_oe ? l2_o : STRAP[2];
  assign l1_i  = l1_oe ? l1_o : STRAP[1];
  phy_status_pins #(.WATCH_W(4), .HOLD_CYCLES(20)) u_phy_status_pins (
    .sys_clk, .resetn, .rx_clk_pin, .rx_coding_err, .rx_sym_bit4, .decoder_bypass,
    .tx_active, .rx_active, .link_100, .full_duplex, .tx_packet, .rx_packet, .watch_bits,
    .mdc, .mdio_i(mdio_line), .mdio_o, .mdio_oe, .rx_err_out, .col_out,
    .mgmt_interrupt_n_i(int_i), .mgmt_interrupt_n_o(int_o), .mgmt_interrupt_n_oe(int_oe),
    .led_out_three_i(l3_i), .led_out_three_o(l3_o), .led_out_three_oe(l3_oe),
    .led_out_two_i(l2_i), .led_out_two_o(l2_o), .led_out_two_oe(l2_oe),
    .led_out_one_i(l1_i), .led_out_one_o(l1_o), .led_out_one_oe(l1_oe),
    .led_out_zero_i(STRAP[0]), .phy_addr, .phy_addr_valid
  );
  mgmt_host u_mgmt_host (.mdio_o, .mdio_oe, .mdc, .mdio_line);
  // ------------------------------
  // clocks, timeout, helpers
  // ------------------------------
  always #4 sys_clk = ~sys_clk;
  // 80 ns receive clock never lands on a system clock rise
  always #40 rx_clk_pin = ~rx_clk_pin;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic mgmt(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd);
    u_mgmt_host.frame(op, pa, ra, wd, rd);
    step(4);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_col();
    tx_active = 1'b1;
    rx_active = 1'b1;
    step(2);
    `CHK(col_out, 1'b1)
    rx_active = 1'b0;
    step(2);
    `CHK(col_out, 1'b0)
    tx_active = 1'b0;
  endtask
  task automatic t_rxerr();
    for (int i = 0; i < 4; i++) begin
      decoder_bypass = i[1];
      rx_coding_err  = i[0];
      rx_sym_bit4    = !i[0];
      step(24);
      `CHK(rx_err_out, i[1] ? !i[0] : i[0])
    end
    decoder_bypass = 1'b0;
    rx_coding_err  = 1'b0;
  endtask
  task automatic t_leds();
    link_100    = 1'b1;
    full_duplex = 1'b1;
    step(3);
    `CHK(l3_i, 1'b0)
    `CHK(l1_i, 1'b0)
    link_100    = 1'b0;
    full_duplex = 1'b0;
    step(3);
    `CHK(l3_i, 1'b1)
    `CHK(l1_i, 1'b1)
    for (int i = 0; i < 2; i++) begin
      tx_packet = !i[0];
      rx_packet = i[0];
      step(1);
      tx_packet = 1'b0;
      rx_packet = 1'b0;
      step(12);
      `CHK(l2_i, 1'b0)
      step(20);
      `CHK(l2_i, 1'b1)
    end
  endtask
  task automatic t_mgmt();
    mgmt(OP_READ, STRAP, REG_ADDR_STAT, 16'h0000);
    `CHK(rd, {11'h000, STRAP})
    mgmt(OP_READ, STRAP ^ 5'h01, REG_ADDR_STAT, 16'h0000);
    `CHK(rd, 16'hffff)
    mgmt(OP_WRITE, STRAP ^ 5'h10, REG_LED_CFG, 16'h0003);
    `CHK(l1_i, 1'b1)
    for (int m = 2; m < 4; m++) begin
      full_duplex = (m == 2);
      mgmt(OP_WRITE, STRAP, REG_LED_CFG, 16'(m));
      `CHK(l1_i, m == 2)
      mgmt(OP_READ, STRAP, REG_LED_CFG, 16'h0000);
      `CHK(rd, 16'(m))
    end
    full_duplex = 1'b1;
    mgmt(OP_WRITE, STRAP, REG_LED_CFG, 16'h0001);
    `CHK(l1_i, 1'b1)
    tx_active = 1'b1;
    rx_active = 1'b1;
    step(3);
    `CHK(l1_i, 1'b0)
    tx_active = 1'b0;
    rx_active = 1'b0;
    step(30);
    `CHK(l1_i, 1'b1)
    full_duplex = 1'b0;
    mgmt(OP_WRITE, STRAP, REG_LED_CFG, 16'h0000);
  endtask
  task automatic t_reset();
    resetn = 1'b0;
    step(3);
    `CHK({phy_addr_valid, int_oe, l3_oe, l2_oe, l1_oe}, 5'h00)
    resetn = 1'b1;
    step(2);
    `CHK(phy_addr, STRAP)
  endtask
  task automatic t_int();
    watch_bits = 4'h1;
    step(4);
    `CHK(int_i, 1'b0)
    step(20);
    `CHK(int_i, 1'b0)
    mgmt(OP_READ, STRAP, REG_INT_STAT, 16'h0000);
    `CHK(rd[3:0], 4'h1)
    `CHK(int_i, 1'b1)
  endtask
  initial begin
    sys_clk    = 1'b0;
    rx_clk_pin = 1'b0;
    resetn     = 1'b0;
    {rx_coding_err, rx_sym_bit4, decoder_bypass, tx_active, rx_active} = '0;
    {link_100, full_duplex, tx_packet, rx_packet} = '0;
    watch_bits = 4'h0;
    step(3);
    `CHK(int_oe | l3_oe | l2_oe | l1_oe, 1'b0)
    resetn = 1'b1;
    step(2);
    `CHK(phy_addr, STRAP)
    `CHK(phy_addr_valid, 1'b1)
    t_col();
    t_rxerr();
    t_leds();
    t_mgmt();
    t_int();
    t_reset();
    report_and_stop();
  end
endmodule
